// ---- common/ee2w_pkg.sv ----
// ----------------------------------------------------------------
// shared constants and types of the two-wire memory link
// ----------------------------------------------------------------
package ee2w_pkg;
  // system clock period, basis of every derived count
  localparam int CLK_PERIOD_NS = 50;
  // least hold of device data after a clock fall
  localparam int TX_HOLD_NS = 300;
  // least time rounds up to whole cycles
  localparam int TX_HOLD_CYC = (TX_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // longest self-timed write cycle
  localparam int TWC_MS = 5;
  // longest time rounds down
  localparam int TWC_CYC = (TWC_MS * 1000000) / CLK_PERIOD_NS;
  // page store depth and array size
  localparam int PAGE_BYTES = 16;
  localparam int MEM_BYTES = 256;
  // device type code in the control byte
  localparam logic [3:0] CTRL_CODE = 4'ha;
  // bit count at which the ninth clock starts
  localparam logic [3:0] BIT_ACK = 4'h8;
  // master quarter bit period in cycles
  localparam int QUARTER_CYC = 20;
  // reset values
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [3:0] CNT_RST = 4'h0;

  // device end states, gray along idle-rx-ack-tx-txack
  typedef enum logic [2:0] {
    EE_IDLE = 3'b000,
    EE_RX = 3'b001,
    EE_ACK = 3'b011,
    EE_TX = 3'b010,
    EE_TX_ACK = 3'b110
  } ee2w_dev_state_type;

  // master end states
  typedef enum logic [1:0] {
    EM_IDLE = 2'b00,
    EM_START = 2'b01,
    EM_BIT = 2'b11,
    EM_STOP = 2'b10
  } ee2w_mst_state_type;

  // master user commands
  typedef enum logic [1:0] {
    CMD_START = 2'b00,
    CMD_STOP = 2'b01,
    CMD_WRITE = 2'b10,
    CMD_READ = 2'b11
  } ee2w_cmd_type;
endpackage

// ---- common/ee2w_if.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// open-drain two-wire link with pull-ups
// ----------------------------------------------------------------
interface ee2w_if;
  logic mst_scl_o; // master clock value, low when enabled
  logic mst_scl_oe_n; // master clock enable, low drives
  logic mst_sda_o; // master data value
  logic mst_sda_oe_n; // master data enable, low drives
  logic dev_sda_o; // device data value
  logic dev_sda_oe_n; // device data enable, low drives
  logic scl; // resolved clock wire
  logic sda; // resolved data wire

  // wired-and with pull-up: released lines read high
  assign scl = mst_scl_oe_n | mst_scl_o;
  assign sda = (mst_sda_oe_n | mst_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
  modport mst (input sda, output mst_scl_o, output mst_scl_oe_n,
               output mst_sda_o, output mst_sda_oe_n);
endinterface

// ---- logic/ee2w_dev_end.sv ----
`timescale 1ns/100ps
// Overview of operation
// RQ1: master alone clocks, arbitrates, frames transfers
// RQ2: master picks direction; device follows it
// RQ3: master starts only on idle bus
// RQ4: data fall with clock high is start
// RQ5: data rise with clock high is stop
// RQ6: data changes only while clock low
// RQ7: one bit per clock, sampled after start
// RQ8: write keeps last sixteen bytes, oldest overwritten
// RQ9: write protect blocks writes, reads still served
// RQ10: three select pins are ignored
// RQ11: device data waits 300 ns after fall
// RQ12: internal write cycle ends within 5 ms
// RQ13: receiver pulls data low on ninth clock
// RQ14: no acknowledge while write cycle runs
// RQ15: control code 1010, last bit selects direction
// RQ16: master nack ends read; device releases data
// RQ17: pins pass two-flop synchronisers first
// RQ18: cycle counter times write from stop
module ee2w_dev_end
  import ee2w_pkg::*;
#(
  parameter int WRITE_CYC = TWC_CYC // shorten in simulation
) (
  input logic clk_sys,
  input logic sys_rst,
  ee2w_if.dev bus,
  input logic write_protect,
  input logic unused_select_pin_0, // RQ10
  input logic unused_select_pin_1, // RQ10
  input logic unused_select_pin_2, // RQ10
  output logic write_busy
);
  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  localparam int TW = $clog2(WRITE_CYC + 1);
  if (WRITE_CYC < PAGE_BYTES) begin : g_chk
    $error("write cycle too short to commit the page store");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic scl_meta_reg, scl_sync_reg, scl_prev_reg; // clock synchroniser
  logic sda_meta_reg, sda_sync_reg, sda_prev_reg; // data synchroniser
  logic wp_meta_reg, wp_sync_reg; // protect synchroniser
  logic scl_rise, scl_fall, start_det, stop_det; // line events
  ee2w_dev_state_type state_reg, state_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next; // bits of current byte
  logic [7:0] shift_reg, shift_next; // rx or tx byte
  logic [1:0] byte_num_reg, byte_num_next; // byte index, saturates at 3
  logic read_mode_reg, read_mode_next; // direction from control byte
  logic [7:0] addr_ptr_reg, addr_ptr_next; // word address pointer
  logic want_low_reg, want_low_next; // level to show after hold
  logic [3:0] dly_reg, dly_next; // hold counter after clock fall
  logic sda_oe_n_reg, sda_oe_n_next; // pin enable, low pulls
  logic ack_seen_reg, ack_seen_next; // master ack after a tx byte
  logic [3:0] page_reg, page_next; // upper address of page store
  logic [PAGE_BYTES-1:0] valid_reg, valid_next; // filled page slots
  logic busy_reg, busy_next; // write cycle in progress
  logic [TW-1:0] twc_reg, twc_next; // write cycle timer
  logic buf_we; // page store write strobe
  logic commit_we; // array write strobe
  logic [7:0] mem_rd; // array read data
  logic [7:0] mem_arr [MEM_BYTES]; // storage array
  logic [7:0] page_buf [PAGE_BYTES]; // page store

  // open-drain: value is always low, only the enable moves
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe_n = sda_oe_n_reg;
  assign write_busy = busy_reg;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // select pins never reach any logic, so their level is moot
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      wp_meta_reg <= 1'b1;
      wp_sync_reg <= 1'b1;
    end else begin
      scl_meta_reg <= bus.scl; // RQ17
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= bus.sda; // RQ17
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
      wp_meta_reg <= write_protect;
      wp_sync_reg <= wp_meta_reg;
    end
  end

  // edges only from synchronised samples
  assign scl_rise = scl_sync_reg & ~scl_prev_reg; // RQ7
  assign scl_fall = ~scl_sync_reg & scl_prev_reg;
  assign start_det = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg; // RQ4
  assign stop_det = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg; // RQ5

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // commit one slot per cycle during the first sixteen timer counts
  assign commit_we = busy_reg && (twc_reg < TW'(PAGE_BYTES)) && valid_reg[twc_reg[3:0]];
  assign mem_rd = mem_arr[addr_ptr_reg];

  // arrays carry no reset; contents are undefined at power up
  always_ff @(posedge clk_sys) begin
    if (buf_we) begin
      page_buf[addr_ptr_reg[3:0]] <= shift_reg; // RQ8
    end
    if (commit_we) begin
      mem_arr[{page_reg, twc_reg[3:0]}] <= page_buf[twc_reg[3:0]];
    end
  end

  // ----------------------------------------------------------------
  // protocol engine, next values
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    byte_num_next = byte_num_reg;
    read_mode_next = read_mode_reg;
    addr_ptr_next = addr_ptr_reg;
    want_low_next = want_low_reg;
    sda_oe_n_next = sda_oe_n_reg;
    ack_seen_next = ack_seen_reg;
    page_next = page_reg;
    valid_next = valid_reg;
    busy_next = busy_reg;
    twc_next = twc_reg;
    buf_we = 1'b0;
    // hold counter: new level shows only once it expires
    dly_next = (dly_reg != CNT_RST) ? dly_reg - 4'h1 : CNT_RST;
    if (dly_reg == 4'h1) begin
      sda_oe_n_next = ~want_low_reg; // RQ11 RQ6
    end
    // write cycle timer, clears the page store at its end
    if (busy_reg) begin
      if (twc_reg == TW'(WRITE_CYC - 1)) begin
        busy_next = 1'b0; // RQ12 RQ18
        valid_next = '0;
      end else begin
        twc_next = twc_reg + TW'(1);
      end
    end
    if (start_det) begin
      // start or repeated start: listen for a control byte
      state_next = EE_RX; // RQ4
      bit_cnt_next = CNT_RST;
      byte_num_next = 2'd0;
      want_low_next = 1'b0;
      sda_oe_n_next = 1'b1;
      dly_next = CNT_RST;
      if (!busy_reg) begin
        valid_next = '0; // unfinished page without stop is dropped
      end
    end else if (stop_det) begin
      state_next = EE_IDLE; // RQ5
      want_low_next = 1'b0;
      sda_oe_n_next = 1'b1;
      dly_next = CNT_RST;
      // stop after stored data launches the write cycle
      if (!busy_reg && (valid_reg != '0) && !wp_sync_reg) begin
        busy_next = 1'b1; // RQ18 RQ9
        twc_next = '0;
      end
    end else begin
      if (scl_fall) begin
        dly_next = 4'(TX_HOLD_CYC); // RQ11
      end
      unique case (state_reg)
        EE_IDLE: begin
          // bits before a start are not data
          state_next = EE_IDLE; // RQ7
        end
        EE_RX: begin
          if (scl_rise && bit_cnt_reg != BIT_ACK) begin
            shift_next = {shift_reg[6:0], sda_sync_reg}; // RQ7
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (scl_fall && bit_cnt_reg == BIT_ACK) begin
            if (byte_num_reg != 2'd3) begin
              byte_num_next = byte_num_reg + 2'd1;
            end
            unique case (byte_num_reg)
              2'd0: begin
                // bits 3..1 are don't care; busy suppresses all ack
                if (shift_reg[7:4] == CTRL_CODE && !busy_reg) begin // RQ15 RQ14
                  state_next = EE_ACK;
                  want_low_next = 1'b1; // RQ13
                  read_mode_next = shift_reg[0]; // RQ2 RQ15
                end else begin
                  state_next = EE_IDLE; // not addressed, stay released
                end
              end
              2'd1: begin
                addr_ptr_next = shift_reg; // word address
                state_next = EE_ACK;
                want_low_next = 1'b1; // RQ13
              end
              default: begin
                state_next = EE_ACK;
                want_low_next = 1'b1; // RQ13
                if (!wp_sync_reg) begin
                  buf_we = 1'b1; // RQ9
                  page_next = addr_ptr_reg[7:4];
                  valid_next[addr_ptr_reg[3:0]] = 1'b1;
                end
                // low nibble rolls, so the sixteenth next overwrites the first
                addr_ptr_next = {addr_ptr_reg[7:4], addr_ptr_reg[3:0] + 4'h1}; // RQ8
              end
            endcase
          end
        end
        EE_ACK: begin
          if (scl_fall) begin
            bit_cnt_next = CNT_RST;
            if (read_mode_reg) begin
              state_next = EE_TX; // RQ2
              shift_next = mem_rd;
              want_low_next = ~mem_rd[7];
            end else begin
              state_next = EE_RX;
              want_low_next = 1'b0;
            end
          end
        end
        EE_TX: begin
          if (scl_rise) begin
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_reg == BIT_ACK) begin
              state_next = EE_TX_ACK;
              want_low_next = 1'b0; // master owns the ninth bit
              addr_ptr_next = addr_ptr_reg + 8'h01;
            end else begin
              shift_next = {shift_reg[6:0], 1'b1};
              want_low_next = ~shift_reg[6]; // RQ6
            end
          end
        end
        EE_TX_ACK: begin
          if (scl_rise) begin
            ack_seen_next = ~sda_sync_reg;
          end else if (scl_fall) begin
            bit_cnt_next = CNT_RST;
            if (ack_seen_reg) begin
              state_next = EE_TX; // sequential read
              shift_next = mem_rd;
              want_low_next = ~mem_rd[7];
            end else begin
              state_next = EE_IDLE; // RQ16
              want_low_next = 1'b0;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // protocol engine, registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= EE_IDLE;
      bit_cnt_reg <= CNT_RST;
      shift_reg <= ADDR_RST;
      byte_num_reg <= 2'd0;
      read_mode_reg <= 1'b0;
      addr_ptr_reg <= ADDR_RST;
      want_low_reg <= 1'b0;
      dly_reg <= CNT_RST;
      sda_oe_n_reg <= 1'b1;
      ack_seen_reg <= 1'b0;
      page_reg <= CNT_RST;
      valid_reg <= '0;
      busy_reg <= 1'b0;
      twc_reg <= '0;
    end else begin
      state_reg <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      byte_num_reg <= byte_num_next;
      read_mode_reg <= read_mode_next;
      addr_ptr_reg <= addr_ptr_next;
      want_low_reg <= want_low_next;
      dly_reg <= dly_next;
      sda_oe_n_reg <= sda_oe_n_next;
      ack_seen_reg <= ack_seen_next;
      page_reg <= page_next;
      valid_reg <= valid_next;
      busy_reg <= busy_next;
      twc_reg <= twc_next;
    end
  end
endmodule // ee2w_dev_end

// ---- logic/ee2w_mst_end.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// bus master end: one command per start, stop, or byte
// ----------------------------------------------------------------
module ee2w_mst_end
  import ee2w_pkg::*;
(
  input logic clk_sys,
  input logic sys_rst,
  ee2w_if.mst bus,
  input logic cmd_valid,
  input ee2w_cmd_type cmd_code,
  input logic [7:0] cmd_wdata,
  input logic cmd_send_ack,
  output logic cmd_ready,
  output logic cmd_done,
  output logic [7:0] rd_data,
  output logic ack_rcvd
);
  if (QUARTER_CYC < 16) begin : g_chk
    $error("quarter period too short for the device hold time");
  end

  ee2w_mst_state_type st_reg, st_next;
  logic sda_meta_reg, sda_sync_reg; // data synchroniser
  logic [7:0] div_reg, div_next; // quarter period divider
  logic [1:0] phase_reg, phase_next; // quarter within a bit
  logic [3:0] bit_cnt_reg, bit_cnt_next; // bits sent this byte
  logic [8:0] shift_reg, shift_next; // byte plus ninth bit
  logic [7:0] rx_reg, rx_next; // sampled bits
  logic scl_oe_n_reg, scl_oe_n_next; // clock enable, low drives
  logic sda_oe_n_reg, sda_oe_n_next; // data enable, low drives
  logic ready_reg, ready_next;
  logic done_reg, done_next;
  logic [7:0] rd_reg, rd_next;
  logic ack_reg, ack_next;
  logic tick; // quarter enable pulse

  assign bus.mst_scl_o = 1'b0;
  assign bus.mst_sda_o = 1'b0;
  assign bus.mst_scl_oe_n = scl_oe_n_reg; // RQ1
  assign bus.mst_sda_oe_n = sda_oe_n_reg;
  assign cmd_ready = ready_reg;
  assign cmd_done = done_reg;
  assign rd_data = rd_reg;
  assign ack_rcvd = ack_reg;
  assign tick = (div_reg == 8'(QUARTER_CYC - 1));

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    div_next = div_reg;
    phase_next = phase_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    rx_next = rx_reg;
    scl_oe_n_next = scl_oe_n_reg;
    sda_oe_n_next = sda_oe_n_reg;
    ready_next = ready_reg;
    done_next = 1'b0;
    rd_next = rd_reg;
    ack_next = ack_reg;
    if (st_reg == EM_IDLE) begin
      if (cmd_valid) begin
        div_next = 8'h00;
        phase_next = 2'd0;
        bit_cnt_next = CNT_RST;
        ready_next = 1'b0;
        // read releases data bits, then drives its own ack
        shift_next = (cmd_code == CMD_READ) ? {8'hff, ~cmd_send_ack} : {cmd_wdata, 1'b1};
        unique case (cmd_code)
          CMD_START: st_next = EM_START; // RQ4
          CMD_STOP: st_next = EM_STOP; // RQ5
          default: st_next = EM_BIT; // RQ2
        endcase
      end
    end else begin
      div_next = tick ? 8'h00 : div_reg + 8'h01;
      if (tick) begin
        phase_next = phase_reg + 2'd1;
        unique case (st_reg)
          EM_START: begin
            // from idle both lines already high, so this is a clean start
            unique case (phase_reg)
              2'd0: sda_oe_n_next = 1'b1; // RQ3
              2'd1: scl_oe_n_next = 1'b1;
              2'd2: sda_oe_n_next = 1'b0; // RQ4
              default: scl_oe_n_next = 1'b0;
            endcase
          end
          EM_STOP: begin
            unique case (phase_reg)
              2'd0: sda_oe_n_next = 1'b0;
              2'd1: scl_oe_n_next = 1'b1;
              2'd2: sda_oe_n_next = 1'b1; // RQ5
              default: sda_oe_n_next = 1'b1;
            endcase
          end
          EM_BIT: begin
            unique case (phase_reg)
              2'd0: sda_oe_n_next = shift_reg[8]; // RQ6
              2'd1: scl_oe_n_next = 1'b1; // RQ7
              2'd2: scl_oe_n_next = 1'b1;
              default: begin
                // sample late in the high phase, then end the pulse
                scl_oe_n_next = 1'b0;
                rx_next = {rx_reg[6:0], sda_sync_reg};
                shift_next = {shift_reg[7:0], 1'b1};
                bit_cnt_next = bit_cnt_reg + 4'h1;
              end
            endcase
          end
          default: st_next = EM_IDLE;
        endcase
        // a command ends on its last quarter
        if (phase_reg == 2'd3 && (st_reg != EM_BIT || bit_cnt_reg == BIT_ACK)) begin
          st_next = EM_IDLE;
          ready_next = 1'b1;
          done_next = 1'b1;
          if (st_reg == EM_BIT) begin
            rd_next = rx_reg;
            ack_next = ~sda_sync_reg; // RQ13 RQ16
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_reg <= EM_IDLE;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      div_reg <= 8'h00;
      phase_reg <= 2'd0;
      bit_cnt_reg <= CNT_RST;
      shift_reg <= 9'h1ff;
      rx_reg <= 8'h00;
      scl_oe_n_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
      ready_reg <= 1'b1;
      done_reg <= 1'b0;
      rd_reg <= 8'h00;
      ack_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      sda_meta_reg <= bus.sda;
      sda_sync_reg <= sda_meta_reg;
      div_reg <= div_next;
      phase_reg <= phase_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      rx_reg <= rx_next;
      scl_oe_n_reg <= scl_oe_n_next;
      sda_oe_n_reg <= sda_oe_n_next;
      ready_reg <= ready_next;
      done_reg <= done_next;
      rd_reg <= rd_next;
      ack_reg <= ack_next;
    end
  end
endmodule // ee2w_mst_end

// ---- verif/ee2w_assertions.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// wire-level checks beside the link
// ----------------------------------------------------------------
module ee2w_assertions
  import ee2w_pkg::*;
(
  input logic clk_sys,
  input logic sys_rst,
  input logic scl,
  input logic sda,
  input logic dev_sda_oe_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // clock low time counter
  // ----------------------------------------------------------------
  logic [4:0] low_cnt_reg; // cycles since clock fall, saturating
  logic [4:0] low_cnt_next;

  // saturate so long idle gaps cannot wrap into the window
  always_comb begin
    low_cnt_next = low_cnt_reg;
    if (scl) begin
      low_cnt_next = 5'h00;
    end else if (low_cnt_reg != 5'h1f) begin
      low_cnt_next = low_cnt_reg + 5'h01;
    end
  end

  // register only
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      low_cnt_reg <= 5'h00;
    end else begin
      low_cnt_reg <= low_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // sequences and properties
  // ----------------------------------------------------------------
  sequence s_idle; scl && sda; endsequence
  sequence s_start; $fell(sda) && scl; endsequence
  sequence s_stop; $rose(sda) && scl; endsequence

  property p_dev_window;
    $changed(dev_sda_oe_n) |-> !scl && low_cnt_reg >= 5'(TX_HOLD_CYC - 1) && low_cnt_reg <= 5'h0e;
  endproperty
  property p_dev_still; scl && $past(scl) |-> $stable(dev_sda_oe_n); endproperty
  property p_start_hold; s_start |-> ##[18:22] $fell(scl); endproperty
  property p_start_idle; s_start |-> $past(scl, 8) && $past(sda, 2); endproperty
  property p_stop_idle; s_stop |-> s_idle [*8]; endproperty
  property p_high_phase; $rose(scl) |-> scl [*8]; endproperty
  property p_low_phase; $fell(scl) |-> !scl [*8]; endproperty
  property p_dev_release; $fell(dev_sda_oe_n) |-> ##[1:800] $rose(dev_sda_oe_n); endproperty

  a_dev_window: assert property (p_dev_window) else $error("device data moved off window");
  a_dev_still: assert property (p_dev_still) else $error("device data moved, clock high");
  a_start_hold: assert property (p_start_hold) else $error("start hold wrong");
  a_start_idle: assert property (p_start_idle) else $error("start not from idle");
  a_stop_idle: assert property (p_stop_idle) else $error("bus not idle after stop");
  a_high_phase: assert property (p_high_phase) else $error("clock high too short");
  a_low_phase: assert property (p_low_phase) else $error("clock low too short");
  a_dev_release: assert property (p_dev_release) else $error("device holds data");
endmodule // ee2w_assertions

// ---- verif/tb_top.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// both ends joined, driven through the master command port
// ----------------------------------------------------------------
module tb_top;
  import ee2w_pkg::*;
  localparam int WCYC = 1000; // long enough to poll once while busy
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic write_protect = 1'b0;
  logic [2:0] sel_pins = 3'h0; // unused select inputs
  logic cmd_valid = 1'b0;
  ee2w_cmd_type cmd_code = CMD_START;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_send_ack = 1'b0;
  logic cmd_ready, cmd_done, ack_rcvd, write_busy;
  logic [7:0] rd_data;
  int err_count = 0;
  int n_checks = 0;

  ee2w_if link();
  ee2w_dev_end #(.WRITE_CYC(WCYC)) u_ee2w_dev_end (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .bus(link), .write_protect(write_protect), .unused_select_pin_0(sel_pins[0]),
    .unused_select_pin_1(sel_pins[1]), .unused_select_pin_2(sel_pins[2]),
    .write_busy(write_busy));
  ee2w_mst_end u_ee2w_mst_end (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus(link),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_send_ack(cmd_send_ack), .cmd_ready(cmd_ready), .cmd_done(cmd_done),
    .rd_data(rd_data), .ack_rcvd(ack_rcvd));
  ee2w_assertions u_ee2w_assertions (.clk_sys(clk_sys), .sys_rst(sys_rst), .scl(link.scl),
    .sda(link.sda), .dev_sda_oe_n(link.dev_sda_oe_n));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  // byte compare
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("BAD %s exp %h got %h", what, exp, got);
      err_count++;
    end
  endtask

  // flag compare, an unknown flag still mismatches
  task automatic chk1(input string what, input logic exp, input logic got);
    chk(what, {7'h00, exp}, {7'h00, got});
  endtask

  // one command; ready is high since the last done
  task automatic op(input ee2w_cmd_type c, input logic [7:0] d, input logic a);
    int n;
    @(negedge clk_sys);
    cmd_code = c;
    cmd_wdata = d;
    cmd_send_ack = a;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    n = 0;
    while (cmd_done !== 1'b1 && n < 1000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk1("done", 1'b1, cmd_done);
  endtask

  // byte out, acknowledge expected or not
  task automatic wr(input logic [7:0] d, input logic e);
    op(CMD_WRITE, d, 1'b0);
    chk1("ack", e, ack_rcvd);
  endtask

  // byte in, master acks when a is set
  task automatic rd(input logic a, input logic [7:0] e);
    op(CMD_READ, 8'hff, a);
    chk("data", e, rd_data);
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, watchdog, tests
  // ----------------------------------------------------------------
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  // about twice the expected run
  initial begin
    repeat (90000) @(posedge clk_sys);
    err_count++;
    conclude();
  end

  initial begin
    repeat (2) @(negedge clk_sys);
    sys_rst = 1'b0;
    chk1("ready", 1'b1, cmd_ready);
    // page write of 17 bytes, odd don't-care bits and select pins
    sel_pins = 3'h5;
    op(CMD_START, 8'h00, 1'b0);
    wr(8'hae, 1'b1);
    wr(8'h30, 1'b1);
    for (int i = 0; i < 17; i++) wr(8'h40 + 8'(i), 1'b1);
    op(CMD_STOP, 8'h00, 1'b0);
    chk1("busy", 1'b1, write_busy);
    op(CMD_START, 8'h00, 1'b0);
    wr(8'ha0, 1'b0);
    op(CMD_STOP, 8'h00, 1'b0);
    repeat (150) @(negedge clk_sys);
    chk1("busy", 1'b0, write_busy);
    // random then sequential read; 17th byte replaced the first
    sel_pins = 3'h2;
    op(CMD_START, 8'h00, 1'b0);
    wr(8'ha0, 1'b1);
    wr(8'h30, 1'b1);
    op(CMD_START, 8'h00, 1'b0);
    wr(8'ha1, 1'b1);
    for (int i = 0; i < 16; i++) rd(i != 15, (i == 0) ? 8'h50 : 8'h40 + 8'(i));
    op(CMD_STOP, 8'h00, 1'b0);
    // wrong type codes get no acknowledge
    foreach (sel_pins[i]) begin
      op(CMD_START, 8'h00, 1'b0);
      wr(8'hb0 ^ 8'(i << 6), 1'b0);
      op(CMD_STOP, 8'h00, 1'b0);
    end
    // protected write is dropped, reads still served; pins move on the falling edge
    @(negedge clk_sys);
    write_protect = 1'b1;
    op(CMD_START, 8'h00, 1'b0);
    wr(8'ha0, 1'b1);
    wr(8'h31, 1'b1);
    wr(8'h99, 1'b1);
    op(CMD_STOP, 8'h00, 1'b0);
    repeat (20) @(negedge clk_sys);
    chk1("busy", 1'b0, write_busy);
    op(CMD_START, 8'h00, 1'b0);
    wr(8'ha0, 1'b1);
    wr(8'h31, 1'b1);
    op(CMD_START, 8'h00, 1'b0);
    wr(8'ha1, 1'b1);
    rd(1'b0, 8'h41);
    op(CMD_STOP, 8'h00, 1'b0);
    // current address read follows the pointer
    op(CMD_START, 8'h00, 1'b0);
    wr(8'ha1, 1'b1);
    rd(1'b0, 8'h42);
    op(CMD_STOP, 8'h00, 1'b0);
    @(negedge clk_sys);
    write_protect = 1'b0;
    conclude();
  end
endmodule // tb_top
